// File: inc/tcrp_regs.svh
`ifndef TCRP_REGS_SVH
`define TCRP_REGS_SVH

// ==========================================
// image geometry
`define TCRP_NUM_BYTES 14
`define TCRP_IMAGE_BITS 112
`define TCRP_CNT_W 7

// ==========================================
// byte positions, byte 1 sits at bit 111..104 of the image
`define TCRP_BYTE_LOW_ZERO 1
`define TCRP_BYTE_MID_ZERO 2
`define TCRP_BYTE_HIGH_ZERO 3
`define TCRP_BYTE_OB_ZERO 4
`define TCRP_BYTE_LOW_GAIN 5
`define TCRP_BYTE_BANDWIDTH 6
`define TCRP_BYTE_MAN_GAIN 7
`define TCRP_BYTE_AMPLITUDE 8
`define TCRP_BYTE_COMMON_MODE 9
`define TCRP_BYTE_BAL_INIT 10
`define TCRP_BYTE_BAL_TEMP 11
`define TCRP_BYTE_OVERLAP 12
`define TCRP_BYTE_LOS_THRESH 13
`define TCRP_BYTE_MODE 14

// ==========================================
// power-up defaults
`define TCRP_RST_LOW_ZERO 8'hff
`define TCRP_RST_MID_ZERO 8'hff
`define TCRP_RST_HIGH_ZERO 8'h80
`define TCRP_RST_OB_ZERO 8'h00
`define TCRP_RST_LOW_GAIN 8'h80
`define TCRP_RST_BANDWIDTH 8'h80
`define TCRP_RST_MAN_GAIN 8'hff
`define TCRP_RST_AMPLITUDE 8'h80
`define TCRP_RST_COMMON_MODE 8'h5a
`define TCRP_RST_BAL_INIT 8'h80
`define TCRP_RST_BAL_TEMP 8'h80
`define TCRP_RST_OVERLAP 8'h80
`define TCRP_RST_LOS_THRESH 8'h80
`define TCRP_RST_MODE 8'h00

// ==========================================
// mode byte fields
`define TCRP_MODE_INPUT_SEL 7
`define TCRP_MODE_AGC_EN 5
`define TCRP_MODE_LOW_ADAPT 4
`define TCRP_MODE_MID_ADAPT 3
`define TCRP_MODE_HIGH_ADAPT 2
`define TCRP_MODE_WMASK 8'hbc

`endif

// File: inc/tcrp_pkg.sv
package tcrp_pkg;

    typedef enum logic [1:0] {
        TCRP_IDLE,
        TCRP_WRITE,
        TCRP_READ
    } tcrp_state_t;

    typedef logic [7:0] tcrp_byte_t;

endpackage : tcrp_pkg

// File: hw/tcrp_port.sv
`timescale 1ns/10ps
`include "tcrp_regs.svh"
// What this block does
// - holds a fourteen-byte control image reached over the three-wire port
// - samples input on rising serial clock, changes output after falling edge
// - write frame updates registers only when select rises, not while shifting
// - read frame starts driving register contents out when select rises
// - all registers take their defaults at power-up without a transfer
// - bytes travel 1 through 14, each most significant bit first
// - bytes 1 to 8 are zeros, output zero, gains, bandwidth, amplitude
// - byte 9 is input common-mode level, default 01011010
// - bytes 10 and 11 are adaptation balance initial and temperature
// - byte 12 is zero range overlap, default 10000000
// - byte 13 is signal loss threshold, default 10000000
// - read/write pulled low, select pulled high when undriven
// - a read never alters any stored control value
// - input select bit picks input one at 0, input two at 1
module tcrp_port #(
    parameter int NUM_BYTES = `TCRP_NUM_BYTES
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic port_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic read_enable_i,
    input wire logic read_enable_drive_i,
    input wire logic port_select_drive_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    output logic [7:0] low_zero_level_o,
    output logic [7:0] mid_zero_level_o,
    output logic [7:0] high_zero_level_o,
    output logic [7:0] output_buffer_zero_level_o,
    output logic [7:0] low_band_gain_level_o,
    output logic [7:0] bandwidth_level_o,
    output logic [7:0] manual_gain_level_o,
    output logic [7:0] amplitude_target_o,
    output logic [7:0] input_common_mode_level_o,
    output logic [7:0] adapt_balance_initial_o,
    output logic [7:0] adapt_balance_temperature_o,
    output logic [7:0] zero_range_overlap_o,
    output logic [7:0] signal_loss_threshold_o,
    output logic second_input_select_o,
    output logic auto_gain_enable_o,
    output logic low_zero_adapt_enable_o,
    output logic mid_zero_adapt_enable_o,
    output logic high_zero_adapt_enable_o
);

    localparam int IMG_W = NUM_BYTES * 8;
    localparam logic [IMG_W-1:0] IMG_RESET = {
        `TCRP_RST_LOW_ZERO,
        `TCRP_RST_MID_ZERO,
        `TCRP_RST_HIGH_ZERO,
        `TCRP_RST_OB_ZERO,
        `TCRP_RST_LOW_GAIN,
        `TCRP_RST_BANDWIDTH,
        `TCRP_RST_MAN_GAIN,
        `TCRP_RST_AMPLITUDE,
        `TCRP_RST_COMMON_MODE,
        `TCRP_RST_BAL_INIT,
        `TCRP_RST_BAL_TEMP,
        `TCRP_RST_OVERLAP,
        `TCRP_RST_LOS_THRESH,
        `TCRP_RST_MODE
    };

    // ==========================================
    // byte extraction, byte 1 is the most significant
    function automatic tcrp_pkg::tcrp_byte_t img_byte(input logic [IMG_W-1:0] img, input int idx);
        img_byte = img[IMG_W - 8*idx +: 8];
    endfunction : img_byte

    // ==========================================
    // reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // ==========================================
    // pin synchronisers; undriven select idles high, undriven read/write means write
    logic [1:0] sel_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] rd_sync_reg;
    wire sel_pin = port_select_drive_i ? port_select_n_i : 1'b1;
    wire rd_pin = read_enable_drive_i ? read_enable_i : 1'b0;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            sel_sync_reg <= 2'h3;
        else
            sel_sync_reg <= {sel_sync_reg[0], sel_pin};
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            sclk_sync_reg <= 2'h0;
        else
            sclk_sync_reg <= {sclk_sync_reg[0], serial_clk_i};
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            sdi_sync_reg <= 2'h0;
        else
            sdi_sync_reg <= {sdi_sync_reg[0], serial_data_i};
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            rd_sync_reg <= 2'h0;
        else
            rd_sync_reg <= {rd_sync_reg[0], rd_pin};
    end

    // ==========================================
    // edge detection on synchronised copies
    logic sel_d_reg;
    logic sclk_d_reg;
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            sel_d_reg <= 1'b1;
        else
            sel_d_reg <= sel_sync_reg[1];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            sclk_d_reg <= 1'b0;
        else
            sclk_d_reg <= sclk_sync_reg[1];
    end

    wire sel_fall = sel_d_reg & ~sel_sync_reg[1];
    wire sel_rise = ~sel_d_reg & sel_sync_reg[1];
    wire sclk_rise = ~sclk_d_reg & sclk_sync_reg[1];
    wire sclk_fall = sclk_d_reg & ~sclk_sync_reg[1];
    wire sel_active = ~sel_sync_reg[1];

    // ==========================================
    // frame state
    tcrp_pkg::tcrp_state_t state_reg;
    tcrp_pkg::tcrp_state_t state_next;
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            tcrp_pkg::TCRP_IDLE:
                if (sel_fall)
                    state_next = rd_sync_reg[1] ? tcrp_pkg::TCRP_READ : tcrp_pkg::TCRP_WRITE;
            tcrp_pkg::TCRP_WRITE:
                if (sel_rise)
                    state_next = tcrp_pkg::TCRP_IDLE;
            tcrp_pkg::TCRP_READ:
                if (sel_fall)
                    state_next = rd_sync_reg[1] ? tcrp_pkg::TCRP_READ : tcrp_pkg::TCRP_WRITE;
            default:
                state_next = tcrp_pkg::TCRP_IDLE;
        endcase
    end

    // ==========================================
    // image, shift path and read-out path
    logic [IMG_W-1:0] image_reg;
    logic [IMG_W-1:0] shift_reg;
    logic [IMG_W-1:0] out_reg;
    logic sdo_reg;
    logic sdo_oe_reg;
    logic [IMG_W-1:0] mode_mask;
    assign mode_mask = {{(IMG_W-8){1'b1}}, `TCRP_MODE_WMASK};
    wire in_write = state_reg == tcrp_pkg::TCRP_WRITE;
    wire in_read = state_reg == tcrp_pkg::TCRP_READ;
    wire write_commit = in_write & sel_rise;
    wire read_start = sel_rise & rd_sync_reg[1] & ~in_write;
    wire read_stop = in_read & sel_fall;
    wire shift_en = in_write & sel_active & sclk_rise;
    wire out_advance = sdo_oe_reg & sclk_fall;
    wire [IMG_W-1:0] shift_next = {shift_reg[IMG_W-2:0], sdi_sync_reg[1]};
    wire [IMG_W-1:0] out_shift = {out_reg[IMG_W-2:0], 1'b0};
    wire [IMG_W-1:0] image_next = write_commit ? (shift_reg & mode_mask) : image_reg;
    logic [IMG_W-1:0] out_next;
    logic sdo_next;
    logic sdo_oe_next;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= tcrp_pkg::TCRP_IDLE;
        else
            state_reg <= state_next;
    end

    // ==========================================
    // control image, committed only when a write frame ends
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            image_reg <= IMG_RESET;
        else
            image_reg <= image_next;
    end

    // ==========================================
    // write shift path
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            shift_reg <= '0;
        else if (shift_en)
            shift_reg <= shift_next;
    end

    // ==========================================
    // read-out next values
    always_comb
    begin
        out_next = out_reg;
        sdo_next = sdo_reg;
        sdo_oe_next = sdo_oe_reg;
        if (read_start)
        begin
            out_next = {image_reg[IMG_W-2:0], 1'b0};
            sdo_next = image_reg[IMG_W-1];
            sdo_oe_next = 1'b1;
        end
        else if (read_stop)
        begin
            out_next = '0;
            sdo_next = 1'b0;
            sdo_oe_next = 1'b0;
        end
        else if (out_advance)
        begin
            out_next = out_shift;
            sdo_next = out_reg[IMG_W-1];
        end
    end

    // ==========================================
    // read-out registers
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            out_reg <= '0;
        else
            out_reg <= out_next;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            sdo_reg <= 1'b0;
        else
            sdo_reg <= sdo_next;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            sdo_oe_reg <= 1'b0;
        else
            sdo_oe_reg <= sdo_oe_next;
    end

    // ==========================================
    // control outputs
    assign low_zero_level_o = img_byte(image_reg, `TCRP_BYTE_LOW_ZERO);
    assign mid_zero_level_o = img_byte(image_reg, `TCRP_BYTE_MID_ZERO);
    assign high_zero_level_o = img_byte(image_reg, `TCRP_BYTE_HIGH_ZERO);
    assign output_buffer_zero_level_o = img_byte(image_reg, `TCRP_BYTE_OB_ZERO);
    assign low_band_gain_level_o = img_byte(image_reg, `TCRP_BYTE_LOW_GAIN);
    assign bandwidth_level_o = img_byte(image_reg, `TCRP_BYTE_BANDWIDTH);
    assign manual_gain_level_o = img_byte(image_reg, `TCRP_BYTE_MAN_GAIN);
    assign amplitude_target_o = img_byte(image_reg, `TCRP_BYTE_AMPLITUDE);
    assign input_common_mode_level_o = img_byte(image_reg, `TCRP_BYTE_COMMON_MODE);
    assign adapt_balance_initial_o = img_byte(image_reg, `TCRP_BYTE_BAL_INIT);
    assign adapt_balance_temperature_o = img_byte(image_reg, `TCRP_BYTE_BAL_TEMP);
    assign zero_range_overlap_o = img_byte(image_reg, `TCRP_BYTE_OVERLAP);
    assign signal_loss_threshold_o = img_byte(image_reg, `TCRP_BYTE_LOS_THRESH);
    assign second_input_select_o = image_reg[`TCRP_MODE_INPUT_SEL];
    assign auto_gain_enable_o = image_reg[`TCRP_MODE_AGC_EN];
    assign low_zero_adapt_enable_o = image_reg[`TCRP_MODE_LOW_ADAPT];
    assign mid_zero_adapt_enable_o = image_reg[`TCRP_MODE_MID_ADAPT];
    assign high_zero_adapt_enable_o = image_reg[`TCRP_MODE_HIGH_ADAPT];
    assign serial_data_o = sdo_reg;
    assign serial_data_oe_o = sdo_oe_reg;

endmodule : tcrp_port

// File: testbench/tcrp_port_checker.sv
`timescale 1ns/10ps
// ==========================================
// port checker
module tcrp_port_checker #(
    parameter int NUM_BYTES = 14
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic port_select_n_i,
    input wire logic port_select_drive_i,
    input wire logic serial_clk_i,
    input wire logic read_enable_i,
    input wire logic read_enable_drive_i,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_o,
    input wire logic [7:0] low_zero_level_o,
    input wire logic [7:0] manual_gain_level_o,
    input wire logic [7:0] input_common_mode_level_o,
    input wire logic [7:0] signal_loss_threshold_o,
    input wire logic second_input_select_o
);
    wire sel_eff = !port_select_drive_i || port_select_n_i;
    wire rd_eff = read_enable_drive_i && read_enable_i;
    wire [32:0] watch = {low_zero_level_o, manual_gain_level_o, input_common_mode_level_o,
        signal_loss_threshold_o, second_input_select_o};
    logic sel_reg;
    logic rd_reg;
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sel_reg <= 1'b1;
            rd_reg <= 1'b0;
        end
        else
        begin
            sel_reg <= sel_eff;
            rd_reg <= (sel_reg && !sel_eff) ? rd_eff : rd_reg;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_read_end;
        !sel_reg && sel_eff && rd_reg;
    endsequence
    sequence s_new_frame;
        sel_reg && !sel_eff;
    endsequence
    property p_defaults;
        $rose(arst_n_i) |-> watch == {8'hff, 8'hff, 8'h5a, 8'h80, 1'b0};
    endproperty
    property p_shift_hold;
        (!sel_eff)[*8] |=> $stable(watch);
    endproperty
    property p_idle_hold;
        sel_eff[*8] |=> $stable(watch);
    endproperty
    property p_read_keep;
        rd_reg |=> $stable(watch);
    endproperty
    property p_oe_start;
        s_read_end |-> ##[1:8] serial_data_oe_o;
    endproperty
    property p_oe_drop;
        s_new_frame |-> ##[1:8] !serial_data_oe_o;
    endproperty
    property p_oe_holds;
        serial_data_oe_o && sel_eff |=> serial_data_oe_o;
    endproperty
    property p_first_bit;
        $rose(serial_data_oe_o) |-> serial_data_o == low_zero_level_o[7];
    endproperty
    property p_change_on_fall;
        serial_data_oe_o && $past(serial_data_oe_o) && $changed(serial_data_o) |-> !serial_clk_i;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults wrong after reset");
    a_shift_hold: assert property (p_shift_hold) else $error("control changed while shifting");
    a_idle_hold: assert property (p_idle_hold) else $error("control changed while idle");
    a_read_keep: assert property (p_read_keep) else $error("control changed in read frame");
    a_oe_start: assert property (p_oe_start) else $error("read output not started");
    a_oe_drop: assert property (p_oe_drop) else $error("read output not released");
    a_oe_holds: assert property (p_oe_holds) else $error("read output dropped early");
    a_first_bit: assert property (p_first_bit) else $error("first bit not byte 1 bit 7");
    a_change_on_fall: assert property (p_change_on_fall) else $error("output moved on high clock");
endmodule : tcrp_port_checker
bind tcrp_port tcrp_port_checker #(.NUM_BYTES(NUM_BYTES)) chk_u (.clk_sys_i, .arst_n_i, .port_select_n_i,
    .port_select_drive_i, .serial_clk_i, .read_enable_i, .read_enable_drive_i, .serial_data_o,
    .serial_data_oe_o, .low_zero_level_o, .manual_gain_level_o, .input_common_mode_level_o,
    .signal_loss_threshold_o, .second_input_select_o);

// File: testbench/tcrp_host_model.sv
`timescale 1ns/10ps
// ==========================================
// host controller on the three-wire port
module tcrp_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic select_n_o,
    output logic sclk_o,
    output logic mosi_o,
    output logic read_en_o,
    output logic read_en_drive_o,
    output logic select_drive_o
);
    initial
    begin
        {select_n_o, sclk_o, mosi_o, read_en_o, read_en_drive_o, select_drive_o} = 6'h04;
    end
    task automatic shift(input logic [111:0] wdat, output logic [111:0] rdat);
        for (int i = 111; i >= 0; i--)
        begin
            mosi_o = wdat[i];
            repeat (6) @(negedge clk_i);
            sclk_o = 1'b1;
            rdat[i] = miso_oe_i ? miso_i : 1'bx;
            repeat (6) @(negedge clk_i);
            sclk_o = 1'b0;
        end
    endtask : shift
    task automatic frame(input logic rd, input logic [111:0] wdat, output logic [111:0] rdat);
        {read_en_drive_o, select_drive_o, read_en_o, select_n_o} = {2'h3, rd, 1'b1};
        repeat (6) @(negedge clk_i);
        select_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        if (!rd)
            shift(wdat, rdat);
        repeat (6) @(negedge clk_i);
        select_n_o = 1'b1;
        repeat (12) @(negedge clk_i);
        if (rd)
            shift(wdat, rdat);
        // released lines show the inverse of their last level
        {select_drive_o, select_n_o, read_en_drive_o, read_en_o, mosi_o} = {3'h0, !rd, 1'b0};
        repeat (6) @(negedge clk_i);
    endtask : frame
endmodule : tcrp_host_model

// File: testbench/tcrp_port_bench.sv
`timescale 1ns/10ps
// ==========================================
// bench top
module tcrp_port_bench;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic port_select_n_i, serial_clk_i, serial_data_i, read_enable_i, read_enable_drive_i;
    logic port_select_drive_i, serial_data_o, serial_data_oe_o;
    logic [7:0] low_zero_level_o, mid_zero_level_o, high_zero_level_o, output_buffer_zero_level_o;
    logic [7:0] low_band_gain_level_o, bandwidth_level_o, manual_gain_level_o, amplitude_target_o;
    logic [7:0] input_common_mode_level_o, adapt_balance_initial_o, adapt_balance_temperature_o;
    logic [7:0] zero_range_overlap_o, signal_loss_threshold_o;
    logic second_input_select_o, auto_gain_enable_o, low_zero_adapt_enable_o;
    logic mid_zero_adapt_enable_o, high_zero_adapt_enable_o;
    logic [111:0] img, model_img, rd_img, wd;
    int err_total = 0;
    int comparisons = 0;
    assign img = {low_zero_level_o, mid_zero_level_o, high_zero_level_o, output_buffer_zero_level_o,
        low_band_gain_level_o, bandwidth_level_o, manual_gain_level_o, amplitude_target_o,
        input_common_mode_level_o, adapt_balance_initial_o, adapt_balance_temperature_o,
        zero_range_overlap_o, signal_loss_threshold_o, second_input_select_o, 1'b0, auto_gain_enable_o,
        low_zero_adapt_enable_o, mid_zero_adapt_enable_o, high_zero_adapt_enable_o, 2'b00};
    always #2 clk_sys_i = ~clk_sys_i;
    tcrp_port #(.NUM_BYTES(14)) dut_u (.clk_sys_i, .arst_n_i, .port_select_n_i, .serial_clk_i,
        .serial_data_i, .read_enable_i, .read_enable_drive_i, .port_select_drive_i, .serial_data_o,
        .serial_data_oe_o, .low_zero_level_o, .mid_zero_level_o, .high_zero_level_o,
        .output_buffer_zero_level_o, .low_band_gain_level_o, .bandwidth_level_o, .manual_gain_level_o,
        .amplitude_target_o, .input_common_mode_level_o, .adapt_balance_initial_o,
        .adapt_balance_temperature_o, .zero_range_overlap_o, .signal_loss_threshold_o,
        .second_input_select_o, .auto_gain_enable_o, .low_zero_adapt_enable_o, .mid_zero_adapt_enable_o,
        .high_zero_adapt_enable_o);
    tcrp_host_model host_u (.clk_i(clk_sys_i), .miso_i(serial_data_o), .miso_oe_i(serial_data_oe_o),
        .select_n_o(port_select_n_i), .sclk_o(serial_clk_i), .mosi_o(serial_data_i),
        .read_en_o(read_enable_i), .read_en_drive_o(read_enable_drive_i),
        .select_drive_o(port_select_drive_i));
    task automatic check_img(input logic [111:0] got, input logic [111:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_img
    task automatic check_read(input logic [111:0] got, input logic [111:0] exp);
        logic [7:0] exp_q[$];
        for (int b = 13; b >= 0; b--)
            exp_q.push_back(exp[8*b +: 8]);
        foreach (exp_q[n])
        begin
            comparisons++;
            if (got[111-8*n -: 8] !== exp_q[n])
            begin
                err_total++;
                $display("ERROR t=%0t byte=%0d got=%h exp=%h", $time, n + 1, got[111-8*n -: 8], exp_q[n]);
            end
        end
    endtask : check_read
    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        #200000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'h7481678e));
        model_img = 112'hffff80008080ff805a8080808000;
        repeat (8) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        check_img(img, model_img);
        for (int k = 0; k < 5; k++)
        begin
            wd = 112'({$urandom, $urandom, $urandom, $urandom});
            if (k > 0)
            begin
                host_u.frame(1'b0, wd, rd_img);
                model_img = wd & ~112'h43;
                repeat (12) @(negedge clk_sys_i);
                check_img(img, model_img);
            end
            host_u.frame(1'b1, ~wd, rd_img);
            check_read(rd_img, model_img);
            check_img(img, model_img);
        end
        arst_n_i = 1'b0;
        model_img = 112'hffff80008080ff805a8080808000;
        repeat (3) @(negedge clk_sys_i);
        check_img(img, model_img);
        arst_n_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        host_u.frame(1'b1, wd, rd_img);
        check_read(rd_img, model_img);
        give_verdict();
    end
endmodule : tcrp_port_bench
